/* File: plsc_port_regs.sv */
// module: apb slave holding port device status and link capability registers
`timescale 1ns/10ps
`default_nettype none
module plsc_port_regs (
  input  wire logic        pclk,            // config clock, 100 MHz
  input  wire logic        presetn,         // async reset, active low
  input  wire logic        psel,            // apb select
  input  wire logic        penable,         // apb access phase
  input  wire logic        pwrite,          // apb direction
  input  wire logic [13:0] paddr,           // apb byte address
  input  wire logic [31:0] pwdata,          // apb write data
  input  wire logic [3:0]  pstrb,           // apb byte strobes
  output logic             pready,          // apb ready
  output logic      [31:0] prdata,          // apb read data
  output logic             pslverr,         // apb error on unmapped
  input  wire logic        is_upstream,     // strap: port faces upstream
  input  wire logic        cap_lock,        // lock on writable caps
  input  wire logic        err_correctable, // one-cycle detect pulses
  input  wire logic        err_nonfatal,
  input  wire logic        err_fatal,
  input  wire logic        err_unsupported,
  input  wire logic        link_active,     // data link active state
  output logic      [3:0]  err_msg_send,    // per class message request
  output logic      [5:0]  lane_width,      // operating width
  output logic             link_active_rpt, // reported link active
  output logic             irq              // level interrupt
);

  ////////////////////////////////////////////////////////////////////////////////
  // decode
  logic        acc;          // access phase
  logic        wr;           // write takes effect this edge
  logic [11:0] idx;          // word index
  logic        hit_sts;
  logic        hit_cap;
  logic        hit_ctl;
  logic        hit_ien;
  logic        hit_iclr;
  logic        hit_ists;
  logic        mapped;

  // address match against a word index, used by every hit term
  function automatic logic is_at(input logic [13:0] a, input logic [11:0] i);
    is_at = (a == 14'((i * plsc_pkg::ADDR_SCALE)));
  endfunction

  assign acc      = psel & penable;
  assign wr       = acc & pwrite;
  assign idx      = paddr[13:2];
  assign hit_sts  = is_at(paddr, plsc_pkg::STS_INDEX);
  assign hit_cap  = is_at(paddr, plsc_pkg::CAP_INDEX);
  assign hit_ctl  = is_at(paddr, plsc_pkg::CTL_INDEX);
  assign hit_ien  = is_at(paddr, plsc_pkg::IEN_INDEX);
  assign hit_iclr = is_at(paddr, plsc_pkg::ICLR_INDEX);
  assign hit_ists = is_at(paddr, plsc_pkg::ISTS_INDEX);
  assign mapped   = hit_sts | hit_cap | hit_ctl | hit_ien | hit_iclr | hit_ists;
  // zero wait states; unmapped answers with an error
  assign pready   = 1'b1;
  assign pslverr  = acc & ~mapped;

  ////////////////////////////////////////////////////////////////////////////////
  // strap capture after reset release, since async reset takes constants only
  logic strap_done;    // strap sampled
  logic upstream;      // captured port direction
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strap_done <= 1'b0;
      upstream   <= 1'b0;
    end else if (!strap_done) begin
      strap_done <= 1'b1;
      upstream   <= is_upstream;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // error flags, sticky, write one clears; set wins over clear
  logic [3:0] err_seen;   // correctable, nonfatal, fatal, unsupported
  logic [3:0] err_in;
  logic [3:0] err_clr;
  assign err_in  = {err_unsupported, err_fatal, err_nonfatal, err_correctable};
  assign err_clr = (wr & hit_sts & pstrb[0]) ? pwdata[3:0] : 4'h0;
  // logged regardless of reporting enables
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      err_seen <= plsc_pkg::ERR_RESET;
    end else begin
      err_seen <= (err_seen & ~err_clr) | err_in;  // R1 R2
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // reporting enables, low byte of the device control word
  logic [3:0] report_en;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      report_en <= plsc_pkg::ERR_RESET;
    end else if (wr && hit_ctl && pstrb[0]) begin
      report_en <= pwdata[3:0];
    end
  end

  // message requests registered so data leaves a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      err_msg_send <= 4'h0;
    end else begin
      err_msg_send <= err_in & report_en;  // R15
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // writable capability fields
  logic [5:0] top_lane_count;
  logic [2:0] standby_exit_delay;
  logic [2:0] sleep_exit_delay;
  logic       refclk_removal_ok;
  logic       surprise_down_report_cap;
  logic       link_active_report_cap;
  logic       cap_wr;
  logic       init_pend;   // load port-type defaults once strap is known
  assign cap_wr = wr & hit_cap & ~cap_lock;  // R16

  // defaults depend on port direction, loaded the cycle after strap capture
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      init_pend <= 1'b1;
    end else if (strap_done) begin
      init_pend <= 1'b0;
    end
  end

  // lane count holds exactly the written value, never touched by hardware
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      top_lane_count <= plsc_pkg::LANE_DEFAULT;
    end else if (cap_wr && pstrb[0] && pstrb[1]) begin
      top_lane_count <= pwdata[plsc_pkg::LANE_HI:plsc_pkg::LANE_LO];  // R5 R7
    end
  end

  // exit delays and clock bit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      standby_exit_delay <= plsc_pkg::SBY_RESET;  // R9
      sleep_exit_delay   <= plsc_pkg::SLP_RESET;  // R10
      refclk_removal_ok  <= plsc_pkg::CLK_RESET;  // R11
    end else if (cap_wr) begin
      if (pstrb[1]) begin
        standby_exit_delay <= pwdata[plsc_pkg::SBY_HI:plsc_pkg::SBY_LO];  // R9
        sleep_exit_delay[0] <= pwdata[plsc_pkg::SLP_LO];  // R10
      end
      if (pstrb[2]) begin
        sleep_exit_delay[2:1] <= pwdata[plsc_pkg::SLP_HI:plsc_pkg::SLP_LO + 1];  // R10
        refclk_removal_ok     <= pwdata[plsc_pkg::CLK_BIT];  // R11
      end
    end
  end

  // port-type dependent capabilities; upstream keeps link active at zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      surprise_down_report_cap <= 1'b0;
      link_active_report_cap   <= 1'b0;
    end else if (init_pend && strap_done) begin
      surprise_down_report_cap <= ~upstream;  // R12
      link_active_report_cap   <= ~upstream;  // R13
    end else if (cap_wr && pstrb[2]) begin
      surprise_down_report_cap <= pwdata[plsc_pkg::SDN_BIT];  // R12
      link_active_report_cap   <= pwdata[plsc_pkg::LAR_BIT] & ~upstream;  // R13
    end
  end

  // operating width falls back on reserved codes
  logic [5:0] next_lane_width;
  plsc_lane_sel u_lane_sel (
    .lane_field (top_lane_count),
    .lane_init  (plsc_pkg::LANE_DEFAULT),
    .lane_width (next_lane_width)
  );
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lane_width <= plsc_pkg::LANE_DEFAULT;
    end else begin
      lane_width <= next_lane_width;  // R6
    end
  end

  // link active reported whatever the advertised bit says
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      link_active_rpt <= 1'b0;
    end else begin
      link_active_rpt <= link_active & ~upstream;  // R14
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // interrupts: sticky status, enable, write-only clear; set beats clear
  logic [3:0] int_sts;
  logic [3:0] int_en;
  logic [3:0] int_clr;
  assign int_clr = (wr & hit_iclr & pstrb[0]) ? pwdata[3:0] : 4'h0;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_sts <= 4'h0;
    end else begin
      int_sts <= (int_sts & ~int_clr) | err_in;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_en <= 4'h0;
    end else if (wr && hit_ien && pstrb[0]) begin
      int_en <= pwdata[3:0];
    end
  end
  assign irq = |(int_sts & int_en);

  ////////////////////////////////////////////////////////////////////////////////
  // read mux
  logic [31:0] cap_word;
  logic [31:0] sts_word;
  always_comb begin
    cap_word = 32'h0;
    cap_word[plsc_pkg::RATE_HI:plsc_pkg::RATE_LO] = plsc_pkg::RATE_VAL;  // R4
    cap_word[plsc_pkg::LANE_HI:plsc_pkg::LANE_LO] = top_lane_count;
    cap_word[plsc_pkg::LPS_HI:plsc_pkg::LPS_LO]   = plsc_pkg::LPS_VAL;   // R8
    cap_word[plsc_pkg::SBY_HI:plsc_pkg::SBY_LO]   = standby_exit_delay;
    cap_word[plsc_pkg::SLP_HI:plsc_pkg::SLP_LO]   = sleep_exit_delay;
    cap_word[plsc_pkg::CLK_BIT] = refclk_removal_ok;
    cap_word[plsc_pkg::SDN_BIT] = surprise_down_report_cap;
    cap_word[plsc_pkg::LAR_BIT] = link_active_report_cap;
  end
  // aux power, pending and reserved bits are zero
  assign sts_word = {28'h0, err_seen};  // R3

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
    end else if (psel && !penable && !pwrite) begin
      // captured in setup so data is flop-driven during access
      if (hit_sts)       prdata <= sts_word;
      else if (hit_cap)  prdata <= cap_word;
      else if (hit_ctl)  prdata <= {28'h0, report_en};
      else if (hit_ien)  prdata <= {28'h0, int_en};
      else if (hit_ists) prdata <= {28'h0, int_sts};
      else               prdata <= 32'h0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // checks
  // legal lane codes; everything else is reserved and must fall back
  function automatic logic lane_legal(input logic [5:0] c);
    lane_legal = (c == plsc_pkg::LANE_X1) || (c == plsc_pkg::LANE_X2) ||
                 (c == plsc_pkg::LANE_X4);
  endfunction

  // write data aimed at the lane field, kept whole so $past sees a plain signal
  logic [5:0] lane_wdata;
  assign lane_wdata = pwdata[plsc_pkg::LANE_HI:plsc_pkg::LANE_LO];

  // named steps, each used by one property
  sequence s_sts_read;   // access phase of a status read
    acc && !pwrite && hit_sts;
  endsequence
  sequence s_cap_read;   // access phase of a caps read
    acc && !pwrite && hit_cap;
  endsequence
  sequence s_init_load;  // edge that loads the port-type defaults
    init_pend && strap_done;
  endsequence
  sequence s_lane_wr;    // write that reaches the whole lane field
    cap_wr && pstrb[0] && pstrb[1];
  endsequence

  // error flags: detection sets, a write of one clears, otherwise they hold
  a_flag_sets: assert property (@(posedge pclk) disable iff (!presetn)  // R1
    err_correctable |=> err_seen[0]) else $error("correctable flag not set");
  a_nonfatal_sets: assert property (@(posedge pclk) disable iff (!presetn)  // R1
    err_nonfatal |=> err_seen[1]) else $error("nonfatal flag not set");
  a_flag_w1c: assert property (@(posedge pclk) disable iff (!presetn)  // R2
    (wr && hit_sts && pstrb[0] && pwdata[2] && !err_fatal) |=> !err_seen[2])
    else $error("fatal flag not cleared");
  a_unsup_hold: assert property (@(posedge pclk) disable iff (!presetn)  // R2
    (err_seen[3] && !err_clr[3]) |=> err_seen[3]) else $error("unsupported flag lost");

  // fixed fields are checked on read data, so the capture flop is covered too
  a_sts_zero: assert property (@(posedge pclk) disable iff (!presetn)  // R3
    s_sts_read |-> (prdata >> plsc_pkg::ERR_BITS) == 32'h0)
    else $error("status high bits nonzero");
  a_rate_fixed: assert property (@(posedge pclk) disable iff (!presetn)  // R4 R8
    s_cap_read |-> prdata[plsc_pkg::RATE_HI:plsc_pkg::RATE_LO] == plsc_pkg::RATE_VAL &&
                   prdata[plsc_pkg::LPS_HI:plsc_pkg::LPS_LO] == plsc_pkg::LPS_VAL)
    else $error("fixed caps wrong");

  // lane field holds what was written; operating width falls back on reserved codes
  a_lane_write: assert property (@(posedge pclk) disable iff (!presetn)  // R5 R7
    s_lane_wr |=> top_lane_count == $past(lane_wdata))
    else $error("lane field not as written");
  a_lane_kept: assert property (@(posedge pclk) disable iff (!presetn)  // R7
    (!(cap_wr && pstrb[0] && pstrb[1])) |=> $stable(top_lane_count))
    else $error("lane field changed by hardware");
  a_lane_fallback: assert property (@(posedge pclk) disable iff (!presetn)  // R6
    !lane_legal(top_lane_count) |=> lane_width == plsc_pkg::LANE_DEFAULT)
    else $error("reserved width not defaulted");
  a_lane_follow: assert property (@(posedge pclk) disable iff (!presetn)  // R5
    lane_legal(top_lane_count) |=> lane_width == $past(top_lane_count))
    else $error("legal width not applied");

  // port-type capabilities and link active reporting
  a_strap_held: assert property (@(posedge pclk) disable iff (!presetn)  // R12
    strap_done |=> $stable(upstream)) else $error("port direction changed");
  a_port_defaults: assert property (@(posedge pclk) disable iff (!presetn)  // R12 R13
    s_init_load |=> surprise_down_report_cap == !upstream &&
                    link_active_report_cap == !upstream)
    else $error("port-type defaults wrong");
  a_up_lar_zero: assert property (@(posedge pclk) disable iff (!presetn)  // R13
    (strap_done && !init_pend && upstream) |-> !link_active_report_cap)
    else $error("upstream link active cap set");
  a_lar_always: assert property (@(posedge pclk) disable iff (!presetn)  // R14
    (strap_done && !upstream && link_active) |=> link_active_rpt)
    else $error("link active not reported");
  a_up_rpt_low: assert property (@(posedge pclk) disable iff (!presetn)  // R13
    (strap_done && upstream) |=> !link_active_rpt)
    else $error("upstream reported link active");

  // messages only leave when the class is enabled, and always then
  a_msg_gated: assert property (@(posedge pclk) disable iff (!presetn)  // R15
    err_msg_send[1] |-> $past(err_nonfatal) && $past(report_en[1]))
    else $error("message without enable");
  a_msg_fatal: assert property (@(posedge pclk) disable iff (!presetn)  // R15
    (err_fatal && report_en[2]) |=> err_msg_send[2]) else $error("fatal message missing");
  a_msg_quiet: assert property (@(posedge pclk) disable iff (!presetn)  // R15
    (report_en == plsc_pkg::ERR_RESET) |=> err_msg_send == plsc_pkg::ERR_RESET)
    else $error("message with all enables off");

  // unmapped writes and locked caps leave the registers alone
  a_unmap_quiet: assert property (@(posedge pclk) disable iff (!presetn)
    (acc && pwrite && !mapped) |=> $stable(report_en) && $stable(int_en) &&
                                   $stable(top_lane_count))
    else $error("unmapped write landed");
  a_lock_holds: assert property (@(posedge pclk) disable iff (!presetn)  // R16
    (cap_lock && !init_pend) |=> $stable(standby_exit_delay) && $stable(sleep_exit_delay))
    else $error("locked field written");
  // an enabled event raises the level interrupt one edge later
  a_irq_raise: assert property (@(posedge pclk) disable iff (!presetn)
    ((|(err_in & int_en)) && !(wr && hit_ien)) |=> irq) else $error("interrupt not raised");

endmodule
`default_nettype wire

/* File: plsc_pkg.sv */
// package: register map, field layout and reset values of the port status / link caps bank
// Contract
// R1 - correctable and nonfatal flags set, write-one clears
// R2 - fatal and unsupported flags set, write-one clears
// R3 - aux power, pending, bits 15:6 read zero
// R4 - top link rate reads 0x2, read-only
// R5 - lane count field 9:4, writable to narrow
// R6 - invalid lane code: port runs default width
// R7 - hardware never alters written lane count
// R8 - low power support fixed at 0x3
// R9 - standby exit delay defaults 0x5, writable
// R10 - sleep exit delay defaults 0x2, writable
// R11 - refclk removal bit defaults zero
// R12 - surprise down cap: downstream one, upstream zero
// R13 - link active cap: downstream one, upstream fixed zero
// R14 - link active cap write only changes advertisement
// R15 - error messages gated by reporting enables
// R16 - lockable fields writable unless lock input set
package plsc_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // word indexes; the byte address is the index times ADDR_SCALE
  localparam logic [11:0] STS_INDEX  = 12'h04a;  // status word index
  localparam logic [11:0] CAP_INDEX  = 12'h04c;  // link caps word index
  localparam logic [11:0] CTL_INDEX  = 12'h048;  // reporting enables
  localparam logic [11:0] IEN_INDEX  = 12'h100;  // interrupt enable
  localparam logic [11:0] ICLR_INDEX = 12'h101;  // interrupt clear, write only
  localparam logic [11:0] ISTS_INDEX = 12'h102;  // interrupt status, read only
  localparam logic [13:0] ADDR_SCALE = 14'h0004; // bytes per word

  ////////////////////////////////////////////////////////////////////////////////
  // status field positions
  localparam int ERR_BITS = 4;                    // four error classes
  localparam logic [3:0] ERR_RESET = 4'h0;        // flags and enables reset
  localparam int STS_W = 16;                      // status register width

  ////////////////////////////////////////////////////////////////////////////////
  // link caps field positions and values
  localparam int RATE_LO = 0;
  localparam int RATE_HI = 3;
  localparam int LANE_LO = 4;
  localparam int LANE_HI = 9;
  localparam int LPS_LO  = 10;
  localparam int LPS_HI  = 11;
  localparam int SBY_LO  = 12;
  localparam int SBY_HI  = 14;
  localparam int SLP_LO  = 15;
  localparam int SLP_HI  = 17;
  localparam int CLK_BIT = 18;
  localparam int SDN_BIT = 19;
  localparam int LAR_BIT = 20;

  localparam logic [3:0] RATE_VAL     = 4'h2;  // 5 Gbps
  localparam logic [1:0] LPS_VAL      = 2'h3;  // both low power states
  localparam logic [2:0] SBY_RESET    = 3'h5;  // 1 to 2 us
  localparam logic [2:0] SLP_RESET    = 3'h2;  // 2 to under 4 us
  localparam logic       CLK_RESET    = 1'h0;  // refclk must stay
  localparam logic [5:0] LANE_X1      = 6'h01;
  localparam logic [5:0] LANE_X2      = 6'h02;
  localparam logic [5:0] LANE_X4      = 6'h04;
  localparam logic [5:0] LANE_DEFAULT = 6'h04; // built width of the port

endpackage

/* File: plsc_lane_sel.sv */
// module: effective lane width from the written lane count field
`timescale 1ns/10ps
`default_nettype none
module plsc_lane_sel (
  input  wire logic [5:0] lane_field,  // value software holds in the field
  input  wire logic [5:0] lane_init,   // initial width of the port
  output logic      [5:0] lane_width   // width the port operates at
);

  // a reserved code falls back to the initial width; field itself untouched
  always_comb begin
    unique case (lane_field)
      plsc_pkg::LANE_X1,
      plsc_pkg::LANE_X2,
      plsc_pkg::LANE_X4: lane_width = lane_field;
      default:           lane_width = lane_init;  // R6
    endcase
  end

endmodule
`default_nettype wire

/* File: pcie_port_status_link_caps_bench.sv */
// testbench: port status and link caps bank checked against a bench model
`timescale 1ns/10ps
`default_nettype none
module pcie_port_status_link_caps_bench;
  ////////////////////////////////////////////////////////////////////////////////
  // byte addresses are index times four
  localparam logic [13:0] a_ctl  = {plsc_pkg::CTL_INDEX, 2'b00};
  localparam logic [13:0] a_sts  = {plsc_pkg::STS_INDEX, 2'b00};
  localparam logic [13:0] a_cap  = {plsc_pkg::CAP_INDEX, 2'b00};
  localparam logic [13:0] a_ien  = {plsc_pkg::IEN_INDEX, 2'b00};
  localparam logic [13:0] a_iclr = {plsc_pkg::ICLR_INDEX, 2'b00};
  localparam logic [13:0] a_ists = {plsc_pkg::ISTS_INDEX, 2'b00};
  localparam logic [31:0] cap_m  = 32'h001fffff;  // bits owned by this block
  logic        pclk        = 1'b0;   // config clock
  logic        presetn     = 1'b0;   // async reset, active low
  logic        psel        = 1'b0;   // apb request
  logic        penable     = 1'b0;
  logic        pwrite      = 1'b0;
  logic [13:0] paddr       = '0;
  logic [31:0] pwdata      = '0;
  logic        pready;
  logic [31:0] prdata;
  logic        pslverr;
  logic        is_upstream = 1'b0;   // port type strap
  logic        cap_lock    = 1'b0;
  logic [3:0]  errs        = '0;     // detect pulses, one per class
  logic        link_active = 1'b0;
  logic [3:0]  err_msg_send;
  logic [5:0]  lane_width;
  logic        link_active_rpt;
  logic        irq;
  int          bad_count   = 0;
  int          tests_run   = 0;
  logic [31:0] lfsr        = 32'h372b1f0f;
  logic [31:0] rd;                   // last read data
  logic        err;                  // last slave error
  logic [31:0] m_caps;               // model of the caps word
  int          lane_q[$];            // expected operating widths

  always #5 pclk = ~pclk;

  plsc_port_regs u_plsc_port_regs (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .is_upstream(is_upstream), .cap_lock(cap_lock),
    .err_correctable(errs[0]), .err_nonfatal(errs[1]), .err_fatal(errs[2]),
    .err_unsupported(errs[3]), .link_active(link_active), .err_msg_send(err_msg_send),
    .lane_width(lane_width), .link_active_rpt(link_active_rpt), .irq(irq)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // helpers
  function automatic logic [31:0] next_rand();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one apb transfer; waits on pready, never assumes a latency
  task automatic apb(input logic w, input logic [13:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) bad_count++;
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // one-cycle detect pulses, then settle past the flag update
  task automatic pulse(input logic [3:0] m);
    @(posedge pclk);
    errs <= m;
    @(posedge pclk);
    errs <= 4'h0;
    #1;
  endtask

  // model: port-type defaults in the caps word
  task automatic do_reset(input logic up);
    presetn <= 1'b0;
    is_upstream <= up;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
    m_caps = {11'h0, ~up, ~up, 1'b0, 3'h2, 3'h5, 2'h3, 6'h04, 4'h2};
  endtask

  // model: writable fields only, link active cap held low upstream
  task automatic caps_write(input logic [31:0] d);
    logic [31:0] wm;
    wm = is_upstream ? 32'h000ff3f0 : 32'h001ff3f0;
    apb(1'b1, a_cap, d);
    if (!cap_lock) m_caps = (m_caps & ~wm) | (d & wm);
    apb(1'b0, a_cap, 32'h0);
    check(rd & cap_m, m_caps);
  endtask

  task automatic give_verdict;
    $display("bad_count=%0d tests_run=%0d", bad_count, tests_run);
    if (bad_count == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // watchdog: the whole sequence needs under five hundred cycles
  initial begin
    repeat (20000) @(posedge pclk);
    bad_count++;
    give_verdict();
  end

  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    logic [31:0] r;
    logic [3:0]  m;
    logic [3:0]  ctl;
    logic [3:0]  ien;
    do_reset(1'b0);
    apb(1'b0, a_ctl, 32'h0);
    check(rd, 32'h0);
    apb(1'b0, a_sts, 32'h0);
    check(rd, 32'h0);
    caps_write(32'h0);
    check(irq, 1'b0);
    // error classes singly, then random mixes and enables
    for (int i = 0; i < 10; i++) begin
      r = next_rand();
      m = (i < 4) ? (4'h1 << i) : r[3:0];
      ctl = (i < 2) ? 4'h0 : ((i < 4) ? 4'hf : r[7:4]);
      ien = r[11:8];
      apb(1'b1, a_ctl, {28'h0, ctl});
      apb(1'b1, a_ien, {28'h0, ien});
      pulse(m);
      check(err_msg_send, m & ctl);
      check(irq, |(m & ien));
      apb(1'b0, a_sts, 32'h0);
      check(rd, m);
      apb(1'b0, a_ists, 32'h0);
      check(rd, m);
      // partial clear; reserved and hardwired bits ignore writes
      apb(1'b1, a_sts, 32'h0000ffc5 & {16'h0, 12'hffc, m | 4'ha});
      apb(1'b0, a_sts, 32'h0);
      check(rd, m & 4'ha);
      apb(1'b1, a_sts, 32'h0000ffff);
      apb(1'b1, a_iclr, 32'h0000000f);
      apb(1'b0, a_sts, 32'h0);
      check(rd, 32'h0);
      check(irq, 1'b0);
      apb(1'b0, a_ctl, 32'h0);
      check(rd, {28'h0, ctl});
    end
    // lane codes 0..7 then random words; link active follows its input
    for (int i = 0; i < 12; i++) begin
      r = next_rand();
      if (i < 8) r[9:4] = i[5:0];
      @(posedge pclk);  // inputs change only on a rising edge
      link_active <= r[31];
      caps_write(r);
      lane_q.push_back((r[9:4] == 6'h01 || r[9:4] == 6'h02 || r[9:4] == 6'h04) ? r[9:4] : 4);
      repeat (2) @(posedge pclk);
      #1;
      check(lane_width, lane_q.pop_front());
      check(link_active_rpt, r[31]);
    end
    // locked caps ignore writes
    cap_lock <= 1'b1;
    @(posedge pclk);
    caps_write(~m_caps);
    cap_lock <= 1'b0;
    // unmapped address is refused
    apb(1'b1, 14'h0200, 32'hffffffff);
    check(err, 1'b1);
    apb(1'b0, 14'h0200, 32'h0);
    check(rd, 32'h0);
    // upstream port: both port-type caps start low, link active stays low
    do_reset(1'b1);
    apb(1'b0, a_cap, 32'h0);
    check(rd & cap_m, m_caps);
    caps_write(32'h001fffff);
    link_active <= 1'b1;
    repeat (2) @(posedge pclk);
    #1;
    check(link_active_rpt, 1'b0);
    give_verdict();
  end
endmodule
`default_nettype wire
